// File: dws_pkg.sv
// Constants, types and step layout for the default write sequence store
// Contract
// - After power-up both the start-up and shut-down sequences run from fixed defaults with no programming.
// - Writing 0100h to the start register 6Fh runs indexes 0..29; writing 0120h runs indexes 32..48.
// - Software may rewrite sequence locations 0..31 with its own steps at any time.
// - User step contents survive a software reset, which is a write to control register zero.
// - Power-down loses user step contents, so the fixed defaults apply after the next power-up.
// - Steps 0..18 enable bias, discharge, reference, gains, mixers, clock, converters, pump, outputs.
// - Step 19 writes 11h to bits 7:0 of register 5Eh with delay code 0h.
// - Step 20 writes 33h to bits 7:0 of register 5Ah.
// - Step 21 writes 33h to bits 7:0 of register 5Eh.
// - Step 22 writes 2h to bits 1:0 of 45h; step 23 writes Fh to bits 3:0 of 43h with delay code Ch.
// - Step 24 writes Fh to bits 3:0 of 43h again with delay code 7h.
// - Step 26 writes 77h to bits 7:0 of register 5Ah.
// - Step 27 writes 77h to bits 7:0 of register 5Eh.
// - The sequencer stops after a step whose end-of-sequence flag is set or after index 63, else goes to the next index.
// - Each step lasts 62.5 us times (two to the delay code plus eight), execution included.
// - Each step updates only the field at its start bit, width code plus one bits, from its low data bits.
package dws_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] A_SOFT_RESET = 8'h00;
    localparam logic [7:0] A_WR_INDEX   = 8'h6C;
    localparam logic [7:0] A_STEP_LO    = 8'h6D;
    localparam logic [7:0] A_STEP_HI    = 8'h6E;
    localparam logic [7:0] A_SEQ_START  = 8'h6F;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int          WIDTH_LSB  = 12;
    localparam int          START_LSB  = 8;
    localparam int          EOS_BIT    = 14;
    localparam int          DELAY_LSB  = 8;
    localparam int          GO_BIT     = 8;
    localparam logic [15:0] LO_MASK    = 16'h7FFF;
    localparam logic [15:0] HI_MASK    = 16'h4FFF;
    localparam logic [15:0] INDEX_MASK = 16'h001F;

    // ------------------------------------------------------------
    // Sequence memory shape
    // ------------------------------------------------------------
    localparam int         RAM_DEPTH  = 32;
    localparam logic [5:0] LAST_INDEX = 6'h3F;
    localparam logic [7:0] FIELD_ONES = 8'hFF;
    localparam logic [2:0] WIDTH_MAX  = 3'h7;

    // ------------------------------------------------------------
    // Step timing
    // ------------------------------------------------------------
    localparam int          UNIT_NS      = 62500;
    localparam int          CLK_MHZ      = 125;
    localparam int          UNIT_CYC_DEF = (UNIT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] DELAY_BIAS   = 16'h0008;
    localparam logic [15:0] ONE16        = 16'h0001;
    localparam logic [27:0] ONE28        = 28'h000_0001;

    // One stored sequence step
    typedef struct packed {
        logic       eos;
        logic [3:0] delay;
        logic [2:0] width;
        logic [3:0] lsb;
        logic [7:0] addr;
        logic [7:0] value;
    } dws_step_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_WAIT = 3'b100
    } dws_state_t;

endpackage

// File: dws_rom.sv
// Fixed default contents of all 64 sequence steps
`timescale 1ns/1ps
module dws_rom
    import dws_pkg::*;
(
    input  wire logic [5:0] idx,   // Step index
    output dws_step_t       step   // Default step at that index
);

    // Pack one step from its fields
    function automatic dws_step_t mk(input logic [7:0] a, input logic [2:0] w,
                                     input logic [3:0] s, input logic [7:0] v,
                                     input logic [3:0] d, input logic e);
        mk = '{eos: e, delay: d, width: w, lsb: s, addr: a, value: v};
    endfunction

    // ------------------------------------------------------------
    // Default table; unlisted indexes are spare steps to FFh
    // ------------------------------------------------------------
    always_comb begin
        case (idx)
            6'h00: step = mk(8'h04, 3'h4, 4'h0, 8'h1A, 4'h0, 1'h0);
            6'h01: step = mk(8'h41, 3'h0, 4'h1, 8'h01, 4'h9, 1'h0);
            6'h02: step = mk(8'h11, 3'h1, 4'h0, 8'h03, 4'h0, 1'h0);
            6'h03: step = mk(8'h41, 3'h0, 4'h1, 8'h00, 4'h0, 1'h0);
            6'h04: step = mk(8'h05, 3'h7, 4'h0, 8'hF7, 4'hB, 1'h0);
            6'h05: step = mk(8'h11, 3'h1, 4'h0, 8'h00, 4'h0, 1'h0);
            6'h06: step = mk(8'h05, 3'h1, 4'h3, 8'h00, 4'h0, 1'h0);
            6'h07: step = mk(8'h05, 3'h1, 4'h1, 8'h01, 4'h0, 1'h0);
            6'h08: step = mk(8'h04, 3'h0, 4'h0, 8'h01, 4'h0, 1'h0);
            6'h09: step = mk(8'h0E, 3'h1, 4'h0, 8'h03, 4'h0, 1'h0);
            6'h0A: step = mk(8'h0D, 3'h1, 4'h0, 8'h03, 4'h0, 1'h0);
            6'h0B: step = mk(8'h0F, 3'h1, 4'h0, 8'h03, 4'h0, 1'h0);
            6'h0C: step = mk(8'h16, 3'h0, 4'h1, 8'h01, 4'h0, 1'h0);
            6'h0D: step = mk(8'h12, 3'h1, 4'h2, 8'h03, 4'h5, 1'h0);
            6'h0F: step = mk(8'h04, 3'h0, 4'h4, 8'h00, 4'h0, 1'h0);
            6'h10: step = mk(8'h62, 3'h0, 4'h0, 8'h01, 4'h6, 1'h0);
            6'h12: step = mk(8'h5A, 3'h7, 4'h0, 8'h11, 4'h0, 1'h0);
            6'h13: step = mk(8'h5E, 3'h7, 4'h0, 8'h11, 4'h0, 1'h0);
            6'h14: step = mk(8'h5A, 3'h7, 4'h0, 8'h33, 4'h0, 1'h0);
            6'h15: step = mk(8'h5E, 3'h7, 4'h0, 8'h33, 4'h0, 1'h0);
            6'h16: step = mk(8'h45, 3'h1, 4'h0, 8'h02, 4'h0, 1'h0);
            6'h17: step = mk(8'h43, 3'h3, 4'h0, 8'h0F, 4'hC, 1'h0);
            6'h18: step = mk(8'h43, 3'h3, 4'h0, 8'h0F, 4'h7, 1'h0);
            6'h1A: step = mk(8'h5A, 3'h7, 4'h0, 8'h77, 4'h0, 1'h0);
            6'h1B: step = mk(8'h5E, 3'h7, 4'h0, 8'h77, 4'h0, 1'h0);
            6'h1C: step = mk(8'h5A, 3'h7, 4'h0, 8'hFF, 4'h0, 1'h0);
            6'h1D: step = mk(8'h5E, 3'h7, 4'h0, 8'hFF, 4'h0, 1'h1);
            6'h20: step = mk(8'h5E, 3'h7, 4'h0, 8'h77, 4'h0, 1'h0);
            6'h21: step = mk(8'h5A, 3'h7, 4'h0, 8'h77, 4'h0, 1'h0);
            6'h22: step = mk(8'h5A, 3'h7, 4'h0, 8'h00, 4'h0, 1'h0);
            6'h23: step = mk(8'h5E, 3'h7, 4'h0, 8'h00, 4'h0, 1'h0);
            6'h24: step = mk(8'h43, 3'h3, 4'h0, 8'h00, 4'h0, 1'h0);
            6'h25: step = mk(8'h62, 3'h0, 4'h0, 8'h00, 4'h0, 1'h0);
            6'h26: step = mk(8'h12, 3'h1, 4'h2, 8'h00, 4'h0, 1'h0);
            6'h27: step = mk(8'h16, 3'h0, 4'h1, 8'h00, 4'h0, 1'h0);
            6'h28: step = mk(8'h0E, 3'h1, 4'h0, 8'h00, 4'h0, 1'h0);
            6'h29: step = mk(8'h0F, 3'h1, 4'h0, 8'h00, 4'h0, 1'h0);
            6'h2A: step = mk(8'h0D, 3'h1, 4'h0, 8'h00, 4'h0, 1'h0);
            6'h2B: step = mk(8'h04, 3'h0, 4'h0, 8'h00, 4'h0, 1'h0);
            6'h30: step = mk(8'hFF, 3'h0, 4'h0, 8'h00, 4'h0, 1'h1);
            default: step = mk(8'hFF, 3'h0, 4'h0, 8'h00, 4'h0, 1'h0);
        endcase
    end

endmodule

// File: dws_top.sv
// Control write sequencer with default step store and launch logic
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
module dws_top
    import dws_pkg::*;
#(
    parameter int UNIT_CYC = UNIT_CYC_DEF   // Cycles per 62.5 us unit
)
(
    input  wire logic        mclk,          // System clock, 125 MHz
    input  wire logic        nrst,          // Power-on reset, sync, active low
    input  wire logic [7:0]  reg_addr,      // Register address
    input  wire logic [15:0] reg_wdata,     // Register write data
    input  wire logic        reg_wr,        // Write strobe
    input  wire logic        reg_rd,        // Read strobe
    output logic      [15:0] reg_rdata,     // Read data, cycle after strobe
    output logic             ctl_we,        // Field write pulse
    output logic      [7:0]  ctl_addr,      // Target control register
    output logic      [15:0] ctl_wdata,     // Field data in place
    output logic      [15:0] ctl_wmask,     // Field bits to update
    output logic             seq_busy       // Sequence running
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        dws_step_t [RAM_DEPTH-1:0] ram;
        logic [RAM_DEPTH-1:0]      user;
        logic [4:0]                widx;
        logic [15:0]               lo;
        logic [15:0]               hi;
        dws_state_t                state;
        logic [5:0]                idx;
        logic [27:0]               cnt;
        logic                      stop;
        logic [15:0]               rdata;
        logic                      we;
        logic [7:0]                addr;
        logic [15:0]               wdata;
        logic [15:0]               wmask;
        logic                      busy;
    } dws_regs_t;

    localparam dws_regs_t REGS_RST = '{state: ST_IDLE, default: '0};

    dws_regs_t s_q;
    dws_regs_t s_d;

    // ------------------------------------------------------------
    // Default table lookups
    // ------------------------------------------------------------
    dws_step_t rom_run;
    dws_step_t rom_prog;
    dws_step_t cur_step;
    dws_step_t prog_step;
    dws_step_t new_step;

    // Step being executed
    dws_rom u_rom_run (
        .idx  (s_q.idx),
        .step (rom_run)
    );

    // Step at the programming index, for read-back
    dws_rom u_rom_prog (
        .idx  ({1'b0, s_q.widx}),
        .step (rom_prog)
    );

    // ------------------------------------------------------------
    // Step selection: user copy overrides the default
    // ------------------------------------------------------------
    always_comb begin
        cur_step = rom_run;
        if (!s_q.idx[5] && s_q.user[s_q.idx[4:0]]) begin
            cur_step = s_q.ram[s_q.idx[4:0]];
        end
        prog_step = rom_prog;
        if (s_q.user[s_q.widx]) begin
            prog_step = s_q.ram[s_q.widx];
        end
    end

    // ------------------------------------------------------------
    // Field placement and step length
    // ------------------------------------------------------------
    logic [7:0]  low_mask;
    logic [15:0] units;
    logic [31:0] total;

    always_comb begin
        low_mask = FIELD_ONES >> (WIDTH_MAX - cur_step.width);
        units    = (ONE16 << cur_step.delay) + DELAY_BIAS;
        total    = 32'(units) * 32'(UNIT_CYC);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.rdata = '0;
        s_d.we    = 1'b0;
        new_step  = '0;

        // Sequencer
        case (s_q.state)
            ST_IDLE: begin
                s_d.busy = 1'b0;
            end
            ST_EXEC: begin
                s_d.we    = 1'b1;
                s_d.addr  = cur_step.addr;
                s_d.wmask = 16'(low_mask) << cur_step.lsb;
                s_d.wdata = 16'(cur_step.value & low_mask) << cur_step.lsb;
                s_d.cnt   = total[27:0] - ONE28;
                s_d.stop  = cur_step.eos || (s_q.idx == LAST_INDEX);
                s_d.state = ST_WAIT;
            end
            ST_WAIT: begin
                s_d.cnt = s_q.cnt - ONE28;
                if (s_q.cnt <= ONE28) begin
                    if (s_q.stop) begin
                        s_d.state = ST_IDLE;
                        s_d.busy  = 1'b0;
                    end else begin
                        s_d.idx   = s_q.idx + 6'h01;
                        s_d.state = ST_EXEC;
                    end
                end
            end
            default: begin
                s_d.state = ST_IDLE;
                s_d.busy  = 1'b0;
            end
        endcase

        // Register reads
        if (reg_rd) begin
            case (reg_addr)
                A_WR_INDEX: begin
                    s_d.rdata = 16'(s_q.widx);
                end
                A_STEP_LO: begin
                    s_d.rdata = (16'(prog_step.width) << WIDTH_LSB)
                              | (16'(prog_step.lsb) << START_LSB)
                              | 16'(prog_step.addr);
                end
                A_STEP_HI: begin
                    s_d.rdata = (16'(prog_step.eos) << EOS_BIT)
                              | (16'(prog_step.delay) << DELAY_LSB)
                              | 16'(prog_step.value);
                end
                A_SEQ_START: begin
                    s_d.rdata = (16'(s_q.busy) << GO_BIT) | 16'(s_q.idx);
                end
                default: begin
                    s_d.rdata = '0;
                end
            endcase
        end

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                A_SOFT_RESET: begin
                    // Soft reset: sequencer and staging only, memory kept
                    s_d.state = ST_IDLE;
                    s_d.busy  = 1'b0;
                    s_d.idx   = '0;
                    s_d.cnt   = '0;
                    s_d.stop  = 1'b0;
                    s_d.widx  = '0;
                    s_d.lo    = '0;
                    s_d.hi    = '0;
                    s_d.we    = 1'b0;
                end
                A_WR_INDEX: begin
                    s_d.widx = reg_wdata[4:0];
                end
                A_STEP_LO, A_STEP_HI: begin
                    if (reg_addr == A_STEP_LO) begin
                        s_d.lo = reg_wdata & LO_MASK;
                    end else begin
                        s_d.hi = reg_wdata & HI_MASK;
                    end
                    new_step.width = s_d.lo[WIDTH_LSB +: 3];
                    new_step.lsb   = s_d.lo[START_LSB +: 4];
                    new_step.addr  = s_d.lo[7:0];
                    new_step.eos   = s_d.hi[EOS_BIT];
                    new_step.delay = s_d.hi[DELAY_LSB +: 4];
                    new_step.value = s_d.hi[7:0];
                    s_d.ram[s_q.widx]  = new_step;
                    s_d.user[s_q.widx] = 1'b1;
                end
                A_SEQ_START: begin
                    if (!reg_wdata[GO_BIT]) begin
                        // Start bit clear stops a running sequence, no late step write
                        s_d.state = ST_IDLE;
                        s_d.busy  = 1'b0;
                        s_d.we    = 1'b0;
                    end else if (s_q.state == ST_IDLE) begin
                        // Any start index allowed, e.g. 33 to skip a step
                        s_d.idx   = reg_wdata[5:0];
                        s_d.state = ST_EXEC;
                        s_d.busy  = 1'b1;
                    end
                end
                default: begin
                    s_d.busy = s_d.busy;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register; power-on reset drops all user steps
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_q <= REGS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from the state register
    // ------------------------------------------------------------
    assign reg_rdata = s_q.rdata;
    assign ctl_we    = s_q.we;
    assign ctl_addr  = s_q.addr;
    assign ctl_wdata = s_q.wdata;
    assign ctl_wmask = s_q.wmask;
    assign seq_busy  = s_q.busy;

endmodule

// File: dws_chk.sv
// Port checker for the default write sequence store
`timescale 1ns/1ps
module dws_chk
    import dws_pkg::*;
#(
    parameter int UNIT_CYC = UNIT_CYC_DEF   // Cycles per delay unit
)
(
    input wire logic        mclk,       // Clock
    input wire logic        nrst,       // Power-on reset
    input wire logic [7:0]  reg_addr,   // Register address
    input wire logic [15:0] reg_wdata,  // Write data
    input wire logic        reg_wr,     // Write strobe
    input wire logic        reg_rd,     // Read strobe
    input wire logic [15:0] reg_rdata,  // Read data
    input wire logic        ctl_we,     // Field write pulse
    input wire logic [7:0]  ctl_addr,   // Target register
    input wire logic [15:0] ctl_wdata,  // Field data
    input wire logic [15:0] ctl_wmask,  // Field mask
    input wire logic        seq_busy    // Sequence running
);
    int   gap_q;
    logic seen_q;

    // Cycles since the last step write, valid once a step was seen
    always_ff @(posedge mclk) begin
        if (!nrst || (reg_wr && (reg_addr == A_SEQ_START || reg_addr == A_SOFT_RESET))) begin
            seen_q <= 1'b0;
        end else if (ctl_we) begin
            seen_q <= 1'b1;
        end
        gap_q <= (!nrst || ctl_we) ? 1 : ((gap_q < 1000000) ? gap_q + 1 : gap_q);
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_go;    reg_wr && reg_addr == A_SEQ_START && reg_wdata[GO_BIT] && !seq_busy; endsequence
    sequence s_quiet; !reg_wr; endsequence
    property p_launch;   s_go ##1 s_quiet |=> ctl_we && seq_busy; endproperty
    property p_busy_rise;
        $rose(seq_busy) |-> $past(reg_wr) && $past(reg_addr) == A_SEQ_START
            && ($past(reg_wdata) & 16'h0100) != 16'h0000;
    endproperty
    property p_we_busy;  ctl_we |-> seq_busy; endproperty
    property p_gap;      ctl_we && seen_q |-> gap_q >= 9 * UNIT_CYC; endproperty
    property p_field;    ctl_we |-> (ctl_wdata & ~ctl_wmask) == 16'h0000; endproperty
    property p_mask;
        ctl_we |-> $countones(ctl_wmask) inside {[1:8]}
            && ((ctl_wmask + (ctl_wmask & (~ctl_wmask + 16'h0001))) & ctl_wmask) == 16'h0000;
    endproperty
    property p_hold;
        !ctl_we && !$past(reg_wr) |-> $stable(ctl_addr) && $stable(ctl_wdata) && $stable(ctl_wmask);
    endproperty
    property p_soft;     reg_wr && reg_addr == A_SOFT_RESET |=> !seq_busy; endproperty
    property p_abort;    reg_wr && reg_addr == A_SEQ_START && !reg_wdata[GO_BIT] |=> !seq_busy; endproperty

    a_launch: assert property (p_launch) else $error("start gave no first step");
    a_busy_rise: assert property (p_busy_rise) else $error("busy rose without start");
    a_we_busy: assert property (p_we_busy) else $error("step write while idle");
    a_gap: assert property (p_gap) else $error("steps closer than nine units");
    a_field: assert property (p_field) else $error("data outside field mask");
    a_mask: assert property (p_mask) else $error("field mask malformed");
    a_hold: assert property (p_hold) else $error("step outputs moved between steps");
    a_soft: assert property (p_soft) else $error("soft reset left sequencer busy");
    a_abort: assert property (p_abort) else $error("abort left sequencer busy");
endmodule

// File: tb.sv
// Self-checking bench for the default write sequence store
`timescale 1ns/1ps
module tb;
    import dws_pkg::*;
    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    localparam int UC = 2;
    logic        mclk, nrst, reg_wr, reg_rd, ctl_we, seq_busy;
    logic [7:0]  reg_addr, ctl_addr;
    logic [15:0] reg_wdata, reg_rdata, ctl_wdata, ctl_wmask;
    int          n_mismatch, num_checks, seed, cyc, last_cyc, last_gap, k;
    logic [31:0] cur, u, exp_q[$], mem[64];
    // Step word: addr, value, lsb, width code, delay, eos
    logic [31:0] rom[49] = '{32'h041A_0400, 32'h4101_1090, 32'h1103_0100, 32'h4100_1000,
        32'h05F7_07B0, 32'h1100_0100, 32'h0500_3100, 32'h0501_1100, 32'h0401_0000, 32'h0E03_0100,
        32'h0D03_0100, 32'h0F03_0100, 32'h1601_1000, 32'h1203_2150, 32'hFF00_0000, 32'h0400_4000,
        32'h6201_0060, 32'hFF00_0000, 32'h5A11_0700, 32'h5E11_0700, 32'h5A33_0700, 32'h5E33_0700,
        32'h4502_0100, 32'h430F_03C0, 32'h430F_0370, 32'hFF00_0000, 32'h5A77_0700, 32'h5E77_0700,
        32'h5AFF_0700, 32'h5EFF_0701, 32'hFF00_0000, 32'hFF00_0000, 32'h5E77_0700, 32'h5A77_0700,
        32'h5A00_0700, 32'h5E00_0700, 32'h4300_0300, 32'h6200_0000, 32'h1200_2100, 32'h1600_1000,
        32'h0E00_0100, 32'h0F00_0100, 32'h0D00_0100, 32'h0400_0000, 32'hFF00_0000, 32'hFF00_0000,
        32'hFF00_0000, 32'hFF00_0000, 32'hFF00_0001};

    dws_top #(.UNIT_CYC(UC)) DUT (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ctl_we(ctl_we), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .ctl_wmask(ctl_wmask),
        .seq_busy(seq_busy));

    // Clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Model helpers and comparisons
    // ------------------------------------------------------------
    function automatic logic [15:0] fmask(input logic [31:0] s);
        fmask = ((16'h0002 << s[10:8]) - 16'h0001) << s[15:12];
    endfunction
    function automatic logic [15:0] fdata(input logic [31:0] s);
        fdata = ({8'h00, s[23:16]} & ((16'h0002 << s[10:8]) - 16'h0001)) << s[15:12];
    endfunction
    function automatic logic [15:0] lo_of(input logic [31:0] s);
        lo_of = {1'b0, s[10:8], s[15:12], s[31:24]};
    endfunction
    function automatic logic [15:0] hi_of(input logic [31:0] s);
        hi_of = {1'b0, s[0], 2'b00, s[7:4], s[23:16]};
    endfunction
    task automatic report(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        report({24'h00_0000, got}, {24'h00_0000, exp});
    endtask
    task automatic chk_step(input logic [39:0] got, input logic [39:0] exp);
        report(got, exp);
    endtask
    task automatic chk_gap(input int got, input int exp);
        report(40'(got), 40'(exp));
    endtask

    // ------------------------------------------------------------
    // Bus tasks and scenarios
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        reg_rd    <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk_rd(reg_rdata, e);
        @(posedge mclk);
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        foreach (mem[i]) mem[i] = (i < 49) ? rom[i] : 32'hFF00_0000;
    endtask
    task automatic check_all();
        for (int i = 0; i < 32; i++) begin
            wr(A_WR_INDEX, 16'(i));
            rd(A_STEP_LO, lo_of(mem[i]));
            rd(A_STEP_HI, hi_of(mem[i]));
        end
    endtask
    task automatic run(input logic [15:0] go, input int first, input bit abort);
        int i;
        exp_q.delete();
        i = first;
        do begin
            exp_q.push_back(mem[i]);
            i++;
        end while (!abort && !mem[i - 1][0] && i < 64);
        last_cyc = -1;
        wr(A_SEQ_START, go);
        rd(A_SEQ_START, 16'h0100 | 16'(first));
        chk_rd(16'(seq_busy), 16'h0001);
        wr(A_SEQ_START, abort ? 16'h0000 : 16'h0121);
        idle();
        for (i = 0; i < 30000 && seq_busy !== 1'b0; i++) @(posedge mclk);
        chk_rd(16'(seq_busy), 16'h0000);
        chk_rd(16'(exp_q.size()), 16'h0000);
    endtask

    // Step monitor, sampled mid-cycle
    always @(negedge mclk) begin
        cyc++;
        if (ctl_we === 1'b1) begin
            if (last_cyc >= 0) chk_gap(cyc - last_cyc, last_gap);
            cur = (exp_q.size() > 0) ? exp_q.pop_front() : 32'h0000_0000;
            chk_step({ctl_addr, ctl_wdata, ctl_wmask}, {cur[31:24], fdata(cur), fmask(cur)});
            last_cyc = cyc;
            last_gap = ((1 << cur[7:4]) + 8) * UC;
        end
    end

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (50000) @(posedge mclk);
        n_mismatch++;
        test_done();
    end

    // Main sequence
    initial begin
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {n_mismatch, num_checks, cyc, last_cyc, last_gap} = '0;
        seed = 32'hc1c6;
        do_reset();
        rd(8'h80, 16'h0000);
        rd(A_SEQ_START, 16'h0000);
        check_all();
        run(16'h0100, 0, 1'b0);
        run(16'h0120, 32, 1'b0);
        run(16'h0121, 33, 1'b0);
        for (k = 0; k < 3; k++) begin
            u = $random(seed);
            mem[k] = {u[31:12], 1'b0, u[10:8], 2'b00, u[5:4], 3'b000, k == 2};
            wr(A_WR_INDEX, 16'(k));
            wr(A_STEP_LO, lo_of(mem[k]));
            wr(A_STEP_HI, hi_of(mem[k]));
            idle();
        end
        check_all();
        run(16'h0100, 0, 1'b0);
        wr(A_SOFT_RESET, 16'h0000);
        idle();
        check_all();
        run(16'h0100, 0, 1'b1);
        do_reset();
        check_all();
        test_done();
    end
endmodule

bind dws_top dws_chk #(.UNIT_CYC(UNIT_CYC)) u_chk (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ctl_we(ctl_we), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .ctl_wmask(ctl_wmask),
    .seq_busy(seq_busy));
